// *** verilog/mio_defines.svh ***
// register offsets, field positions, reset values and timing counts of the mixed io channel block
`ifndef MIO_DEFINES_SVH
`define MIO_DEFINES_SVH
// ==========================================================================
// register offsets (byte addresses on the register port)
`define MIO_ADDR_INPUT_STATE_LOW 14'h0000
`define MIO_ADDR_INPUT_STATE_HIGH 14'h0001
`define MIO_ADDR_OUTPUT_DRIVE_LOW 14'h0002
`define MIO_ADDR_OUTPUT_DRIVE_HIGH 14'h0003
`define MIO_ADDR_COUNT_VALUE_ONE 14'h0004
`define MIO_ADDR_COUNT_VALUE_TWO 14'h0006
`define MIO_ADDR_DIRECTION_MASK_LOW 14'h0010
`define MIO_ADDR_DIRECTION_MASK_HIGH 14'h0011
`define MIO_ADDR_DEBOUNCE_SETTING 14'h0012
`define MIO_ADDR_COUNTER_ONE_SETUP 14'h0014
`define MIO_ADDR_COUNTER_TWO_SETUP 14'h0016
`define MIO_ADDR_EDGE_CAPTURE_LOW 14'h001a
`define MIO_ADDR_EDGE_CAPTURE_HIGH 14'h001b
`define MIO_ADDR_EDGE_CLEAR_LOW 14'h001c
`define MIO_ADDR_EDGE_CLEAR_HIGH 14'h001d
`define MIO_ADDR_OUTPUT_FAULT_LOW 14'h001e
`define MIO_ADDR_OUTPUT_FAULT_HIGH 14'h001f
`define MIO_ADDR_MODULE_IDENTITY 14'h2000
`define MIO_ADDR_SUPPLY_LIMITS_FLAGS 14'h2004
`define MIO_ADDR_INPUT_SUPPLY_LEVEL 14'h2010
`define MIO_ADDR_OUTPUT_SUPPLY_LEVEL 14'h2012
`define MIO_ADDR_SERIAL_NUMBER 14'h2020
`define MIO_ADDR_HARDWARE_VERSION 14'h2024
// ==========================================================================
// reset values
`define MIO_RESET_CONFIG 8'h00
// ==========================================================================
// counter setup fields
`define MIO_TB_LSB 0
`define MIO_TB_MSB 2
`define MIO_CLEAR_BIT 5
`define MIO_MODE_LSB 6
`define MIO_MODE_MSB 7
`define MIO_TB_48MHZ 3'h0
`define MIO_TB_3MHZ 3'h1
`define MIO_TB_187K 3'h2
`define MIO_MODE_EVENT 2'h0
`define MIO_MODE_GATE 2'h1
// ==========================================================================
// timing
`define MIO_CLK_HZ 100000000
`define MIO_FILTER_UNIT_US 100
`define MIO_SAMPLE_US 200
`define MIO_SAMPLE_CYCLES ((`MIO_CLK_HZ / 1000000) * `MIO_SAMPLE_US)
`define MIO_FILTER_MAX 8'hfa
`define MIO_OUTPUT_MON_MS 10
`define MIO_OUTPUT_MON_CYCLES ((`MIO_CLK_HZ / 1000) * `MIO_OUTPUT_MON_MS)
`define MIO_TB_48MHZ_HZ 48000000
`define MIO_TB_3MHZ_HZ 3000000
`define MIO_TB_187K_HZ 187500
// phase step of a 32 bit accumulator: rate * 2^32 / clock
`define MIO_STEP(hz) ((64'(hz) << 32) / 64'(`MIO_CLK_HZ))
`endif

// *** verilog/mio_pkg.sv ***
// types shared by the mixed io channel block
package mio_pkg;
  // ========================================================================
  // function model selected by the controller
  typedef enum logic [7:0] {
    MIO_MODEL_COUNTER = 8'h01,
    MIO_MODEL_STANDARD = 8'h02,
    MIO_MODEL_FIELDBUS = 8'hfe
  } mio_model_t;
  // register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic wide;
    logic [13:0] addr;
    logic [15:0] wdata;
  } mio_req_t;
  // counter setup register fields
  typedef struct packed {
    logic [1:0] mode;
    logic clear;
    logic [1:0] rsvd;
    logic [2:0] timebase;
  } mio_cnt_setup_t;
endpackage

// *** verilog/mio_channel_regs.sv ***
// register file, input filter, edge latches, output monitor and counters of sixteen io channels
`include "mio_defines.svh"
module mio_channel_regs #(
  parameter logic [15:0] MODULE_ID = 16'h0a5c, // arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001, // arbitrary value
  parameter logic [15:0] HARDWARE_VERSION = 16'h0001, // arbitrary value
  parameter int SAMPLE_CYCLES = `MIO_SAMPLE_CYCLES,
  parameter int MON_CYCLES = `MIO_OUTPUT_MON_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire mio_pkg::mio_model_t model,
  input wire mio_pkg::mio_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic err,
  output logic [1:0] logical_slots,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_sense,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  input wire logic [7:0] supply_flags_in,
  input wire logic [7:0] input_supply_in,
  input wire logic [7:0] output_supply_in
);
  // ========================================================================
  // helpers
  function automatic logic [15:0] sync_take(input logic [15:0] old_v, input logic [15:0] b,
                                            input logic [15:0] c);
    sync_take = (b == c) ? c : old_v; // change counts once stages two and three agree
  endfunction
  function automatic logic [31:0] tb_step(input logic [2:0] code);
    case (code)
      `MIO_TB_48MHZ: tb_step = 32'(`MIO_STEP(`MIO_TB_48MHZ_HZ));
      `MIO_TB_3MHZ: tb_step = 32'(`MIO_STEP(`MIO_TB_3MHZ_HZ));
      `MIO_TB_187K: tb_step = 32'(`MIO_STEP(`MIO_TB_187K_HZ));
      default: tb_step = 32'h0; // reserved codes: gate clock stands still
    endcase
  endfunction
  // ========================================================================
  // registers
  logic [15:0] direction;
  logic [7:0] debounce_setting;
  logic [7:0] counter_one_setup;
  logic [7:0] counter_two_setup;
  logic [15:0] output_drive;
  logic [15:0] edge_clear;
  logic [15:0] edge_capture;
  logic [15:0] output_fault;
  logic [15:0] in_s1, in_s2, in_s3, in_sync;
  logic [15:0] sense_s1, sense_s2, sense_s3, sense_sync;
  logic [15:0] sampled, filtered, filtered_d;
  logic [15:0] count_value_one, count_value_two;
  logic [15:0] sample_cnt;
  logic sample_tick;
  logic [7:0] eff_filter;
  logic [7:0] stable_cnt [16];
  logic [23:0] mon_cnt [16];
  logic [31:0] gate_acc;
  logic gate_tick;
  logic gate_run;
  logic [15:0] gate_time;
  mio_pkg::mio_cnt_setup_t setup_one, setup_two;
  logic wr_lo, wr_hi, wide_fb;

  assign setup_one = mio_pkg::mio_cnt_setup_t'(counter_one_setup);
  assign setup_two = mio_pkg::mio_cnt_setup_t'(counter_two_setup);
  assign wide_fb = req.wide && (model == mio_pkg::MIO_MODEL_FIELDBUS);
  assign wr_lo = req.wr;
  assign wr_hi = req.wr && wide_fb;
  // ========================================================================
  // configuration writes; in fieldbus model the high byte of a 16-bit write lands at addr+1
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      direction <= 16'h0000;
      debounce_setting <= `MIO_RESET_CONFIG;
    end else if (wr_lo) begin
      if (req.addr == `MIO_ADDR_DIRECTION_MASK_LOW) begin
        direction[7:0] <= req.wdata[7:0];
        if (wr_hi) begin
          direction[15:8] <= req.wdata[15:8];
        end
      end else if (req.addr == `MIO_ADDR_DIRECTION_MASK_HIGH) begin
        direction[15:8] <= req.wdata[7:0];
      end else if (req.addr == `MIO_ADDR_DEBOUNCE_SETTING) begin
        debounce_setting <= req.wdata[7:0];
      end
    end
  end
  // counter setup registers; the clear bit acts on the write and is not held
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      counter_one_setup <= `MIO_RESET_CONFIG;
      counter_two_setup <= `MIO_RESET_CONFIG;
    end else if (wr_lo && req.addr == `MIO_ADDR_COUNTER_ONE_SETUP) begin
      counter_one_setup <= req.wdata[7:0] & ~(8'h01 << `MIO_CLEAR_BIT);
    end else if (wr_lo && req.addr == `MIO_ADDR_COUNTER_TWO_SETUP) begin
      counter_two_setup <= req.wdata[7:0] & ~(8'h01 << `MIO_CLEAR_BIT);
    end
  end
  // output switching state and edge acknowledge words
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      output_drive <= 16'h0000;
      edge_clear <= 16'h0000;
    end else if (wr_lo) begin
      if (req.addr == `MIO_ADDR_OUTPUT_DRIVE_LOW) begin
        output_drive[7:0] <= req.wdata[7:0];
        if (wr_hi) begin
          output_drive[15:8] <= req.wdata[15:8];
        end
      end else if (req.addr == `MIO_ADDR_OUTPUT_DRIVE_HIGH) begin
        output_drive[15:8] <= req.wdata[7:0];
      end else if (req.addr == `MIO_ADDR_EDGE_CLEAR_LOW) begin
        edge_clear[7:0] <= req.wdata[7:0];
      end else if (req.addr == `MIO_ADDR_EDGE_CLEAR_HIGH) begin
        edge_clear[15:8] <= req.wdata[7:0];
      end
    end
  end
  // ========================================================================
  // pin synchronisers, three stages each
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      in_s1 <= 16'h0000;
      in_s2 <= 16'h0000;
      in_s3 <= 16'h0000;
      in_sync <= 16'h0000;
      sense_s1 <= 16'h0000;
      sense_s2 <= 16'h0000;
      sense_s3 <= 16'h0000;
      sense_sync <= 16'h0000;
    end else begin
      in_s1 <= pin_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_sync <= sync_take(in_sync, in_s2, in_s3);
      sense_s1 <= pin_sense;
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      sense_sync <= sync_take(sense_sync, sense_s2, sense_s3);
    end
  end
  // ========================================================================
  // 200 us sampling tick
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sample_cnt <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (sample_cnt == 16'(SAMPLE_CYCLES - 1));
      sample_cnt <= (sample_cnt == 16'(SAMPLE_CYCLES - 1)) ? 16'h0000 : sample_cnt + 16'h0001;
    end
  end
  // clamp and halve: one sample covers two filter units
  assign eff_filter = ((debounce_setting > `MIO_FILTER_MAX) ? `MIO_FILTER_MAX
                       : debounce_setting) >> 1;
  // per-channel debounce: a new level is taken once stable for the delay
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sampled <= 16'h0000;
      filtered <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        stable_cnt[i] <= 8'h00;
      end
    end else if (sample_tick) begin
      sampled <= in_sync;
      for (int i = 0; i < 16; i++) begin
        if (direction[i] || eff_filter == 8'h00) begin
          filtered[i] <= in_sync[i]; // outputs and filter 0 pass unfiltered
          stable_cnt[i] <= 8'h00;
        end else if (in_sync[i] != sampled[i]) begin
          stable_cnt[i] <= 8'h00; // glitch restarts the delay
        end else if (in_sync[i] == filtered[i]) begin
          stable_cnt[i] <= 8'h00;
        end else if (stable_cnt[i] + 8'h01 >= eff_filter) begin
          filtered[i] <= in_sync[i];
          stable_cnt[i] <= 8'h00;
        end else begin
          stable_cnt[i] <= stable_cnt[i] + 8'h01;
        end
      end
    end
  end
  // ========================================================================
  // rising-edge latches, acknowledge dominates and holds clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filtered_d <= 16'h0000;
      edge_capture <= 16'h0000;
    end else begin
      filtered_d <= filtered;
      edge_capture <= ~edge_clear & (edge_capture | (filtered & ~filtered_d));
    end
  end
  // ========================================================================
  // output monitor: mismatch of sense against target for the delay raises a fault
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      output_fault <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        mon_cnt[i] <= 24'h000000;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (!direction[i] || sense_sync[i] == output_drive[i]) begin
          mon_cnt[i] <= 24'h000000; // inputs unmonitored
          if (!direction[i]) begin
            output_fault[i] <= 1'b0;
          end
        end else if (mon_cnt[i] == 24'(MON_CYCLES - 1)) begin
          output_fault[i] <= 1'b1;
        end else begin
          mon_cnt[i] <= mon_cnt[i] + 24'h000001;
        end
        if (output_drive[i] != pin_out[i]) begin
          output_fault[i] <= 1'b0; // a change of target clears the fault flag; the mismatch count is kept
        end
      end
    end
  end
  // pin drivers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
    end else begin
      pin_out <= output_drive & direction;
      pin_oe <= direction;
    end
  end
  // ========================================================================
  // gate timebase by phase accumulator
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gate_acc <= 32'h0;
      gate_tick <= 1'b0;
    end else begin
      {gate_tick, gate_acc} <= {1'b0, gate_acc} + {1'b0, tb_step(setup_one.timebase)};
    end
  end
  // counter one: falling edges on input 1 or gate time on input 2
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_value_one <= 16'h0000;
      gate_time <= 16'h0000;
      gate_run <= 1'b0;
    end else if (wr_lo && req.addr == `MIO_ADDR_COUNTER_ONE_SETUP
                 && req.wdata[`MIO_CLEAR_BIT]) begin
      count_value_one <= 16'h0000;
      gate_time <= 16'h0000;
      gate_run <= 1'b0;
    end else if (setup_one.mode == `MIO_MODE_GATE) begin
      if (in_sync[1] && !gate_run) begin
        gate_run <= 1'b1;
        gate_time <= 16'h0000;
      end else if (gate_run && !in_sync[1]) begin
        gate_run <= 1'b0;
        count_value_one <= gate_time; // result taken at the falling edge
      end else if (gate_run && gate_tick && gate_time != 16'hffff) begin
        gate_time <= gate_time + 16'h0001; // saturates at overflow
      end
    end else if (setup_one.mode == `MIO_MODE_EVENT && filtered_d[0] && !filtered[0]) begin
      count_value_one <= count_value_one + 16'h0001;
    end
  end
  // counter two: falling edges on input 3
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_value_two <= 16'h0000;
    end else if (wr_lo && req.addr == `MIO_ADDR_COUNTER_TWO_SETUP
                 && req.wdata[`MIO_CLEAR_BIT]) begin
      count_value_two <= 16'h0000;
    end else if (setup_two.mode == `MIO_MODE_EVENT && filtered_d[2] && !filtered[2]) begin
      count_value_two <= count_value_two + 16'h0001;
    end
  end
  // ========================================================================
  // read port: one cycle after rd, input state and output fault as 16-bit words on wide reads in fieldbus model
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      err <= 1'b0;
      logical_slots <= 2'h0;
    end else begin
      logical_slots <= (model == mio_pkg::MIO_MODEL_FIELDBUS) ? 2'h2 : 2'h1;
      rvalid <= req.rd;
      err <= 1'b0;
      rdata <= 16'h0000;
      if (req.rd) begin
        if (req.addr == `MIO_ADDR_INPUT_STATE_LOW) begin
          rdata <= wide_fb ? filtered : {8'h00, filtered[7:0]};
        end else if (req.addr == `MIO_ADDR_INPUT_STATE_HIGH) begin
          rdata <= {8'h00, filtered[15:8]};
        end else if (req.addr == `MIO_ADDR_COUNT_VALUE_ONE) begin
          rdata <= count_value_one;
        end else if (req.addr == `MIO_ADDR_COUNT_VALUE_TWO) begin
          rdata <= count_value_two;
        end else if (req.addr == `MIO_ADDR_EDGE_CAPTURE_LOW) begin
          rdata <= {8'h00, edge_capture[7:0]};
        end else if (req.addr == `MIO_ADDR_EDGE_CAPTURE_HIGH) begin
          rdata <= {8'h00, edge_capture[15:8]};
        end else if (req.addr == `MIO_ADDR_OUTPUT_FAULT_LOW) begin
          rdata <= wide_fb ? output_fault : {8'h00, output_fault[7:0]};
        end else if (req.addr == `MIO_ADDR_OUTPUT_FAULT_HIGH) begin
          rdata <= {8'h00, output_fault[15:8]};
        end else if (req.addr == `MIO_ADDR_MODULE_IDENTITY) begin
          rdata <= MODULE_ID;
        end else if (req.addr == `MIO_ADDR_SUPPLY_LIMITS_FLAGS) begin
          rdata <= {8'h00, supply_flags_in};
        end else if (req.addr == `MIO_ADDR_INPUT_SUPPLY_LEVEL) begin
          rdata <= {8'h00, input_supply_in};
        end else if (req.addr == `MIO_ADDR_OUTPUT_SUPPLY_LEVEL) begin
          rdata <= {8'h00, output_supply_in};
        end else if (req.addr == `MIO_ADDR_SERIAL_NUMBER) begin
          rdata <= SERIAL_NUMBER[15:0];
        end else if (req.addr == `MIO_ADDR_SERIAL_NUMBER + 14'h0002) begin
          rdata <= SERIAL_NUMBER[31:16];
        end else if (req.addr == `MIO_ADDR_HARDWARE_VERSION) begin
          rdata <= HARDWARE_VERSION;
        end else begin
          err <= 1'b1; // write-only or unmapped reads answer zero with err
        end
      end
    end
  end
endmodule

// *** dv/mio_bus_ctrl_model.sv ***
// behavioural bus controller that issues register accesses to the channel block
module mio_bus_ctrl_model (
  input wire logic clock,
  output mio_pkg::mio_model_t model,
  output mio_pkg::mio_req_t req,
  input wire logic [15:0] rdata,
  input wire logic err
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // idle request, default model of a fixed controller
  initial begin
    model = mio_pkg::MIO_MODEL_FIELDBUS;
    req = '0;
  end
  // model choice, only changed while the block is held in reset
  task automatic set_model(input mio_pkg::mio_model_t m);
    model = m;
  endtask
  // one access: set after a falling edge, taken at the next rising edge
  task automatic access(input logic rd, input logic wide, input logic [13:0] addr,
                        input logic [15:0] wdata, output logic [15:0] q, output logic e);
    @(negedge clock);
    req = '{rd, ~rd, wide, addr, wdata};
    @(negedge clock);
    q = rdata;
    e = err;
    // released qualifiers show inverted values, not the last ones
    req = '{1'b0, 1'b0, ~wide, ~addr, ~wdata};
  endtask
endmodule

// *** dv/mio_channel_regs_chk.sv ***
// concurrent checks on the ports of the mixed io channel register block
module mio_channel_regs_chk #(
  parameter int SAMPLE_CYCLES = 20000,
  parameter int MON_CYCLES = 1000000
) (
  input wire logic clock,
  input wire logic reset,
  input wire mio_pkg::mio_model_t model,
  input wire mio_pkg::mio_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic err,
  input wire logic [1:0] logical_slots,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========================================================================
  // register port answers
  rd_answer_a: assert property (1 |=> rvalid == $past(req.rd))
    else $error("read answer not one cycle after request");
  idle_data_a: assert property (!rvalid |-> rdata == 16'h0000)
    else $error("read data not zero outside answer");
  err_pair_a: assert property (err |-> rvalid)
    else $error("error flag without answer");
  wo_read_a: assert property (req.rd && req.addr inside {14'h0010, 14'h0012, 14'h0014}
    |=> err && rdata == 16'h0000)
    else $error("write only register read without error");
  wide_fault_a: assert property (req.rd && req.wide && model == mio_pkg::MIO_MODEL_FIELDBUS
    && req.addr == 14'h001e |=> rvalid && !err)
    else $error("wide fault word read refused");
  // ==========================================================================
  // direction and drive of the channel pins
  mask_low_a: assert property (req.wr && !req.wide && req.addr == 14'h0010
    |=> ##1 pin_oe[7:0] == $past(req.wdata[7:0], 2))
    else $error("direction mask not applied");
  out_gate_a: assert property ((pin_out & ~pin_oe) == 16'h0000)
    else $error("input channel driven");
  drive_low_a: assert property (req.wr && !req.wide && req.addr == 14'h0002
    ##1 !(req.wr && req.addr[13:1] == 13'h0001)
    |=> pin_out[7:0] == ($past(req.wdata[7:0], 2) & $past(pin_oe[7:0])))
    else $error("output drive byte not applied");
  slots_a: assert property (!$past(reset) |-> logical_slots
    == ((model == mio_pkg::MIO_MODEL_FIELDBUS) ? 2'h2 : 2'h1))
    else $error("logical slot count wrong");
endmodule
bind mio_channel_regs mio_channel_regs_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
  .MON_CYCLES(MON_CYCLES)) i_mio_channel_regs_chk (.clock(clock), .reset(reset),
  .model(model), .req(req), .rdata(rdata), .rvalid(rvalid), .err(err),
  .logical_slots(logical_slots), .pin_out(pin_out), .pin_oe(pin_oe));

// *** dv/testbench.sv ***
// self-checking bench of the mixed io channel register block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MON = 50;
  typedef struct {
    logic rd;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
    logic exp_err;
    logic [15:0] exp_out;
  } mio_row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  mio_pkg::mio_model_t model;
  mio_pkg::mio_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  logic err;
  logic [1:0] logical_slots;
  logic [15:0] pin_in = 16'h8001;
  logic [15:0] pin_sense = 16'h0000;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] q;
  logic e;
  int n_fail = 0;
  int n_tests = 0;
  mio_row_t rows [14];
  // ==========================================================================
  // design, controller model and clock
  mio_channel_regs #(.SAMPLE_CYCLES(20), .MON_CYCLES(MON)) i_mio_channel_regs (
    .clock(clock), .reset(reset), .model(model), .req(req), .rdata(rdata),
    .rvalid(rvalid), .err(err), .logical_slots(logical_slots), .pin_in(pin_in),
    .pin_sense(pin_sense), .pin_out(pin_out), .pin_oe(pin_oe), .supply_flags_in(8'h5a),
    .input_supply_in(8'h33), .output_supply_in(8'hc4));
  mio_bus_ctrl_model i_mio_bus_ctrl_model (.clock(clock), .model(model), .req(req),
    .rdata(rdata), .err(err));
  initial forever #5 clock = ~clock;
  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic wide, input logic [13:0] a, input logic [15:0] x,
                    input logic xe);
    i_mio_bus_ctrl_model.access(1'b1, wide, a, 16'h0000, q, e);
    chk("rdata", q, x);
    chk("err", {15'h0000, e}, {15'h0000, xe});
  endtask
  task automatic wr(input logic wide, input logic [13:0] a, input logic [15:0] d);
    i_mio_bus_ctrl_model.access(1'b0, wide, a, d, q, e);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic restart(input mio_pkg::mio_model_t m);
    @(negedge clock);
    reset = 1'b1;
    i_mio_bus_ctrl_model.set_model(m);
    cycles(6);
    reset = 1'b0;
    cycles(60);
  endtask
  // gate measurement on input 2 with the given setup byte, result left in q
  task automatic gate(input logic [15:0] setup, input int len);
    wr(1'b0, 14'h0014, setup);
    pin_in[1] = 1'b1;
    cycles(len);
    pin_in[1] = 1'b0;
    cycles(10);
    i_mio_bus_ctrl_model.access(1'b1, 1'b0, 14'h0004, 16'h0000, q, e);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // bound on the whole run
  initial begin
    cycles(20000);
    n_fail++;
    end_of_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    rows[0] = '{1'b1, 14'h0010, 16'h0, 16'h0, 1'b1, 16'h0};
    rows[1] = '{1'b1, 14'h0012, 16'h0, 16'h0, 1'b1, 16'h0};
    rows[2] = '{1'b1, 14'h0014, 16'h0, 16'h0, 1'b1, 16'h0};
    rows[3] = '{1'b1, 14'h3000, 16'h0, 16'h0, 1'b1, 16'h0};
    rows[4] = '{1'b1, 14'h0000, 16'h0, 16'h0001, 1'b0, 16'h0};
    rows[5] = '{1'b1, 14'h0001, 16'h0, 16'h0080, 1'b0, 16'h0};
    rows[6] = '{1'b1, 14'h001a, 16'h0, 16'h0001, 1'b0, 16'h0};
    rows[7] = '{1'b1, 14'h001b, 16'h0, 16'h0080, 1'b0, 16'h0};
    rows[8] = '{1'b1, 14'h2004, 16'h0, 16'h005a, 1'b0, 16'h0};
    rows[9] = '{1'b1, 14'h2010, 16'h0, 16'h0033, 1'b0, 16'h0};
    rows[10] = '{1'b0, 14'h0011, 16'h0002, 16'h0, 1'b0, 16'h0};
    rows[11] = '{1'b0, 14'h0003, 16'h00ff, 16'h0, 1'b0, 16'h0200};
    rows[12] = '{1'b0, 14'h0002, 16'h0001, 16'h0, 1'b0, 16'h0200};
    rows[13] = '{1'b0, 14'h0010, 16'h0001, 16'h0, 1'b0, 16'h0201};
    restart(mio_pkg::MIO_MODEL_STANDARD);
    chk("slots", {14'h0000, logical_slots}, 16'h0001);
    chk("pin_oe", pin_oe, 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].rd) begin
        rd(1'b0, rows[i].addr, rows[i].exp, rows[i].exp_err);
      end else begin
        wr(1'b0, rows[i].addr, rows[i].wdata);
      end
      cycles(1);
      chk("pin_out", pin_out, rows[i].exp_out);
    end
    // output monitoring, reset by a drive change or a change to input
    cycles(MON + 10);
    rd(1'b0, 14'h001f, 16'h0002, 1'b0);
    rd(1'b0, 14'h001e, 16'h0001, 1'b0);
    wr(1'b0, 14'h0003, 16'h0000);
    rd(1'b0, 14'h001f, 16'h0000, 1'b0);
    wr(1'b0, 14'h0010, 16'h0000);
    rd(1'b0, 14'h001e, 16'h0000, 1'b0);
    // short pulse suppressed, long level passed, latch clear dominates
    wr(1'b0, 14'h0012, 16'h0006);
    pin_in[1] = 1'b1;
    cycles(30);
    pin_in[1] = 1'b0;
    cycles(100);
    rd(1'b0, 14'h0000, 16'h0001, 1'b0);
    pin_in[1] = 1'b1;
    cycles(100);
    rd(1'b0, 14'h0000, 16'h0003, 1'b0);
    rd(1'b0, 14'h001a, 16'h0003, 1'b0);
    wr(1'b0, 14'h001c, 16'h0002);
    rd(1'b0, 14'h001a, 16'h0001, 1'b0);
    pin_in[1] = 1'b0;
    cycles(100);
    pin_in[1] = 1'b1;
    cycles(100);
    rd(1'b0, 14'h001a, 16'h0001, 1'b0);
    // largest setting limited to 125 samples
    wr(1'b0, 14'h0012, 16'h00ff);
    pin_in[2] = 1'b1;
    cycles(2530);
    rd(1'b0, 14'h0000, 16'h0007, 1'b0);
    // counter model: falling edges of inputs 1 and 3, separate clears
    pin_in = 16'h0000;
    restart(mio_pkg::MIO_MODEL_COUNTER);
    wr(1'b0, 14'h0010, 16'h0030);
    repeat (3) begin
      pin_in = 16'h0005;
      cycles(50);
      pin_in = 16'h0000;
      cycles(50);
    end
    rd(1'b0, 14'h0004, 16'h0003, 1'b0);
    rd(1'b0, 14'h0006, 16'h0003, 1'b0);
    wr(1'b0, 14'h0016, 16'h0020);
    rd(1'b0, 14'h0006, 16'h0000, 1'b0);
    rd(1'b0, 14'h0004, 16'h0003, 1'b0);
    wr(1'b0, 14'h0014, 16'h0020);
    rd(1'b0, 14'h0004, 16'h0000, 1'b0);
    // gate measurement: input 2 high time counted at 48 MHz, then at 3 MHz
    gate(16'h0040, 100);
    chk("gate_48mhz", {15'h0000, (q >= 16'h002e) && (q <= 16'h0031)}, 16'h0001);
    gate(16'h0041, 1000);
    chk("gate_3mhz", {15'h0000, (q >= 16'h001c) && (q <= 16'h001f)}, 16'h0001);
    // fieldbus model: 16 bit words, two slots
    pin_in = 16'h8001;
    restart(mio_pkg::MIO_MODEL_FIELDBUS);
    chk("slots", {14'h0000, logical_slots}, 16'h0002);
    rd(1'b1, 14'h0000, 16'h8001, 1'b0);
    wr(1'b0, 14'h0010, 16'h00ff);
    wr(1'b1, 14'h0002, 16'h1234);
    cycles(1);
    chk("pin_out", pin_out, 16'h0034);
    cycles(MON + 10);
    rd(1'b1, 14'h001e, 16'h0034, 1'b0);
    end_of_test();
  end
endmodule
